// File: inc/mdu_pkg.sv
// Shared types and constants of the multiply/divide unit.
`default_nettype none
package mdu_pkg;

  localparam int unsigned WORD = 32;
  localparam int unsigned HALF = 16;
  localparam int unsigned BYTE = 8;
  localparam int unsigned TRIPLE = 24;
  localparam logic [5:0] WORD_ITERS = 6'h20;
  localparam logic [5:0] LAST_CNT = 6'h01;
  localparam logic [5:0] STALL_CNT = 6'h02;

  // Divide figures per dividend class: 0 = 8 bits, 1 = 16, 2 = 24, 3 = 32.
  localparam logic [3:0][5:0] DIV_LAT  = {6'h21, 6'h1A, 6'h13, 6'h0C};
  localparam logic [3:0][5:0] DIV_SKIP = {6'h00, 6'h07, 6'h0F, 6'h17};

  typedef enum logic [2:0] {
    MDU_OP_MULT,
    MDU_OP_MADD,
    MDU_OP_MSUB,
    MDU_OP_MUL3,
    MDU_OP_DIV
  } mdu_op_e;

  typedef enum logic [1:0] {
    MDU_DIV_IDLE,
    MDU_DIV_PAD,
    MDU_DIV_RUN
  } mdu_div_state_e;

  typedef struct packed {
    mdu_op_e     op;
    logic        isSigned;
    logic [31:0] firstSrc;
    logic [31:0] secondSrc;
  } mdu_req_s;

endpackage : mdu_pkg
`default_nettype wire

// File: design/mdu_booth_mul.sv
// Radix-4 Booth-recoded 33x17 signed multiplier array.
`timescale 1ns/1ps
`default_nettype none
module mdu_booth_mul (
  input  wire logic signed [32:0] mcand,
  input  wire logic signed [16:0] mplier,
  output logic signed [49:0]      product
);

  wire logic [18:0]        recode = {mplier[16], mplier, 1'b0};
  wire logic signed [49:0] mc50   = {{17{mcand[32]}}, mcand};
  logic signed [49:0]      pp [9];

  // Returns {negate, double, single} for one Booth digit.
  function automatic logic [2:0] boothDigit(input logic [2:0] bits);
    case (bits)
      3'h1, 3'h2: boothDigit = 3'h1;
      3'h3:       boothDigit = 3'h2;
      3'h4:       boothDigit = 3'h6;
      3'h5, 3'h6: boothDigit = 3'h5;
      default:    boothDigit = 3'h0;
    endcase
  endfunction : boothDigit

  genvar i;
  generate
    for (i = 0; i < 9; i++) begin : g_pp
      wire logic [2:0]        dig = boothDigit(recode[2*i+2 -: 3]);
      wire logic signed [49:0] mag = dig[1] ? (mc50 <<< 1) : (dig[0] ? mc50 : 50'h0);
      assign pp[i] = (dig[2] ? -mag : mag) <<< (2 * i);
    end
  endgenerate

  always_comb begin
    product = 50'h0;
    for (int k = 0; k < 9; k++) begin
      product = product + pp[k];
    end
  end

endmodule : mdu_booth_mul
`default_nettype wire

// File: design/mdu_muldiv_unit.sv
// Multiply/divide unit with its own pipeline, result pair and iterative divider.
`timescale 1ns/1ps
`default_nettype none
module mdu_muldiv_unit (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              reqValid,
  input  wire mdu_pkg::mdu_req_s req,
  output logic                   issueStall_q,
  output logic [31:0]            resultHigh_q,
  output logic [31:0]            resultLow_q,
  output logic                   gprValid_q,
  output logic [31:0]            gprData_q
);

  // True when the value fits the given width as a signed or unsigned number.
  function automatic logic fitsWidth(input logic [31:0] v, input logic sgn, input int unsigned w);
    logic [31:0] hiMask;
    hiMask = 32'hFFFFFFFF << (w - 1);
    if (sgn) fitsWidth = ((v & hiMask) == 32'h0) || ((v & hiMask) == hiMask);
    else fitsWidth = (v & (hiMask << 1)) == 32'h0;
  endfunction : fitsWidth

  wire logic [31:0]     opA = req.firstSrc;
  wire logic [31:0]     opB = req.secondSrc;
  wire logic            sgn = req.isSigned;
  wire mdu_pkg::mdu_op_e op = req.op;

  wire logic take   = clkEn && reqValid && !issueStall_q;
  wire logic isDiv  = op == mdu_pkg::MDU_OP_DIV;
  wire logic isMul  = !isDiv;
  wire logic bNarrow = fitsWidth(opB, sgn, mdu_pkg::HALF);
  wire logic wideTake = take && isMul && !bNarrow;

  // Multiplier state for the second pass of a full-width multiply, and the MUL3 result stage.
  logic              secPass_q;
  mdu_pkg::mdu_op_e  savedOp_q;
  logic [32:0]       mulA_q;
  logic [16:0]       mulBhi_q;
  logic [63:0]       partLo_q;
  logic              stageV_q;
  logic [31:0]       stage_q;

  wire logic [32:0] mcandSel  = secPass_q ? mulA_q : {sgn & opA[31], opA};
  wire logic [16:0] mplierSel = secPass_q ? mulBhi_q : {bNarrow & sgn & opB[15], opB[15:0]};
  logic signed [49:0] passOut;

  mdu_booth_mul u_mul (
    .mcand   (mcandSel),
    .mplier  (mplierSel),
    .product (passOut)
  );

  wire logic [63:0] passExt  = {{14{passOut[49]}}, passOut};
  wire logic [63:0] passProd = secPass_q ? ((passExt << 16) + partLo_q) : passExt;
  wire mdu_pkg::mdu_op_e finOp = secPass_q ? savedOp_q : op;
  wire logic mulFinish = secPass_q || (take && isMul && bNarrow);
  wire logic pairWrite = mulFinish && (finOp != mdu_pkg::MDU_OP_MUL3);
  wire logic mul3Write = mulFinish && (finOp == mdu_pkg::MDU_OP_MUL3);

  // Divider state.
  mdu_pkg::mdu_div_state_e divState_q;
  logic [5:0]  divCnt_q;
  logic [5:0]  divIters_q;
  logic [31:0] divRem_q;
  logic [31:0] divQ_q;
  logic [31:0] divisor_q;
  logic        negQ_q;
  logic        negR_q;

  wire logic [1:0] divCls = fitsWidth(opA, sgn, mdu_pkg::BYTE) ? 2'h0 :
                            fitsWidth(opA, sgn, mdu_pkg::HALF) ? 2'h1 :
                            fitsWidth(opA, sgn, mdu_pkg::TRIPLE) ? 2'h2 : 2'h3;
  wire logic [5:0]  clsLat   = mdu_pkg::DIV_LAT[divCls];
  wire logic [5:0]  clsIters = mdu_pkg::WORD_ITERS - mdu_pkg::DIV_SKIP[divCls];
  wire logic [31:0] magA     = (sgn && opA[31]) ? -opA : opA;
  wire logic [31:0] magB     = (sgn && opB[31]) ? -opB : opB;

  wire logic [32:0] shifted  = {divRem_q, divQ_q[31]};
  wire logic [32:0] trial    = shifted - {1'b0, divisor_q};
  wire logic        qBit     = !trial[32];
  wire logic [31:0] iterRem  = qBit ? trial[31:0] : shifted[31:0];
  wire logic [31:0] iterQ    = {divQ_q[30:0], qBit};
  wire logic        divRun   = divState_q == mdu_pkg::MDU_DIV_RUN;
  wire logic        divFinish = clkEn && divRun && (divCnt_q == mdu_pkg::LAST_CNT);
  wire logic [31:0] divQuot  = negQ_q ? -iterQ : iterQ;
  wire logic [31:0] divRemOut = negR_q ? -iterRem : iterRem;

  wire logic [63:0] accBase = divFinish ? {divRemOut, divQuot} : {resultHigh_q, resultLow_q};
  wire logic [63:0] pairNew = (finOp == mdu_pkg::MDU_OP_MADD) ? accBase + passProd :
                              (finOp == mdu_pkg::MDU_OP_MSUB) ? accBase - passProd : passProd;

  wire logic divBusyNext = (divState_q != mdu_pkg::MDU_DIV_IDLE) && (divCnt_q > mdu_pkg::STALL_CNT);
  wire logic stallNext   = wideTake || (take && isDiv) || divBusyNext;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      issueStall_q <= 1'b0;
      secPass_q    <= 1'b0;
    end else if (clkEn) begin
      issueStall_q <= stallNext;
      secPass_q    <= wideTake;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      savedOp_q <= mdu_pkg::MDU_OP_MULT;
      mulA_q    <= 33'h0;
      mulBhi_q  <= 17'h0;
      partLo_q  <= 64'h0;
    end else if (wideTake) begin
      savedOp_q <= op;
      mulA_q    <= mcandSel;
      mulBhi_q  <= {sgn & opB[31], opB[31:16]};
      partLo_q  <= passExt;
    end
  end

  // Result pair: a MULT/MADD/MSUB finishing with the divide writes the pair, MADD/MSUB on top of the divide result.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resultHigh_q <= 32'h0;
      resultLow_q  <= 32'h0;
    end else if (clkEn && pairWrite) begin
      {resultHigh_q, resultLow_q} <= pairNew;
    end else if (divFinish) begin
      {resultHigh_q, resultLow_q} <= {divRemOut, divQuot};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stageV_q   <= 1'b0;
      stage_q    <= 32'h0;
      gprValid_q <= 1'b0;
      gprData_q  <= 32'h0;
    end else if (clkEn) begin
      stageV_q   <= mul3Write;
      stage_q    <= passProd[31:0];
      gprValid_q <= stageV_q;
      gprData_q  <= stage_q;
    end
  end

  // Divide engine runs on clkEn only, never on integer-side stalls.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divState_q <= mdu_pkg::MDU_DIV_IDLE;
      divCnt_q   <= 6'h00;
      divIters_q <= 6'h00;
      divRem_q   <= 32'h0;
      divQ_q     <= 32'h0;
      divisor_q  <= 32'h0;
      negQ_q     <= 1'b0;
      negR_q     <= 1'b0;
    end else if (clkEn) begin
      if (take && isDiv) begin
        divState_q <= (clsLat - mdu_pkg::LAST_CNT) > clsIters ? mdu_pkg::MDU_DIV_PAD
                                                             : mdu_pkg::MDU_DIV_RUN;
        divCnt_q   <= clsLat - mdu_pkg::LAST_CNT;
        divIters_q <= clsIters;
        divRem_q   <= 32'h0;
        divQ_q     <= magA << mdu_pkg::DIV_SKIP[divCls];
        divisor_q  <= magB;
        negQ_q     <= sgn & (opA[31] ^ opB[31]);
        negR_q     <= sgn & opA[31];
      end else begin
        case (divState_q)
          mdu_pkg::MDU_DIV_PAD: begin
            divCnt_q <= divCnt_q - mdu_pkg::LAST_CNT;
            if (divCnt_q == divIters_q + mdu_pkg::LAST_CNT) divState_q <= mdu_pkg::MDU_DIV_RUN;
          end
          mdu_pkg::MDU_DIV_RUN: begin
            divCnt_q <= divCnt_q - mdu_pkg::LAST_CNT;
            divRem_q <= iterRem;
            divQ_q   <= iterQ;
            if (divCnt_q == mdu_pkg::LAST_CNT) divState_q <= mdu_pkg::MDU_DIV_IDLE;
          end
          default: divState_q <= mdu_pkg::MDU_DIV_IDLE;
        endcase
      end
    end
  end

  // Reference values read only by the checks below.
  wire logic signed [64:0] extA   = {{33{sgn & opA[31]}}, opA};
  wire logic signed [64:0] extB   = {{33{sgn & opB[31]}}, opB};
  wire logic [63:0]        refProd = 64'(extA * extB);
  wire logic signed [32:0] divA33 = {sgn & opA[31], opA};
  wire logic signed [32:0] divB33 = {sgn & opB[31], opB};
  wire logic [31:0]        refQuot = 32'(divA33 / divB33);
  wire logic [31:0]        refRem  = 32'(divA33 % divB33);
  wire logic               opMult = take && (op == mdu_pkg::MDU_OP_MULT);
  wire logic               opMul3 = take && (op == mdu_pkg::MDU_OP_MUL3);
  wire logic               opDiv  = take && isDiv && (opB != 32'h0);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !clkEn);

  a_mult_narrow_lat: assert property (opMult && bNarrow |=>
    {resultHigh_q, resultLow_q} == $past(refProd)) else $error("narrow multiply result late or wrong");
  a_mult_wide_lat: assert property (opMult && !bNarrow |=>
    issueStall_q ##1 ({resultHigh_q, resultLow_q} == $past(refProd, 2)))
    else $error("wide multiply not two passes");
  a_narrow_no_stall: assert property (take && isMul && bNarrow |=> !issueStall_q)
    else $error("single-pass multiply blocked the next issue");
  a_wide_interlock: assert property (wideTake |=> issueStall_q && secPass_q && !take)
    else $error("second wide multiply not held off");
  a_mul3_narrow_lat: assert property (opMul3 && bNarrow |=> !gprValid_q ##1
    (gprValid_q && gprData_q == $past(refProd[31:0], 2))) else $error("mul3 narrow result wrong");
  a_mul3_wide_lat: assert property (opMul3 && !bNarrow |=> !gprValid_q ##2
    (gprValid_q && gprData_q == $past(refProd[31:0], 3))) else $error("mul3 wide result wrong");
  a_div_byte_lat: assert property (opDiv && divCls == 2'h0 |-> ##12
    ({resultHigh_q, resultLow_q} == $past({refRem, refQuot}, 12))) else $error("byte divide wrong");
  a_div_half_lat: assert property (opDiv && divCls == 2'h1 |-> ##19
    ({resultHigh_q, resultLow_q} == $past({refRem, refQuot}, 19))) else $error("half divide wrong");
  a_div_word_stall: assert property (take && isDiv && divCls == 2'h3 |->
    ##1 issueStall_q ##30 issueStall_q ##1 !issueStall_q) else $error("word divide stall length wrong");
  a_div_tri_repeat: assert property (take && isDiv && divCls == 2'h2 |->
    ##24 issueStall_q ##1 !issueStall_q) else $error("24-bit divide repeat wrong");

  c_wide_mult: cover property (wideTake);
  c_madd_b2b: cover property (take && op == mdu_pkg::MDU_OP_MADD ##1 take);
  c_div_stalled: cover property (divRun && reqValid && issueStall_q);
  c_div_byte: cover property (opDiv && divCls == 2'h0);

endmodule : mdu_muldiv_unit
`default_nettype wire

// File: test/mdu_pipe_model.sv
// Issuing side model that presents requests and holds them while stalled.
`timescale 1ns/1ps
`default_nettype none
module mdu_pipe_model (
  input  wire logic            sys_clk,
  input  wire logic            issueStall_q,
  output var  logic            reqValid,
  output var  mdu_pkg::mdu_req_s req
);
  int edges = 0;

  initial begin
    reqValid = 1'b0;
    req      = '0;
  end

  always @(posedge sys_clk) begin
    edges <= edges + 1;
  end

  // Holds the request steady until an edge with the stall low takes it.
  task automatic issue(input mdu_pkg::mdu_req_s r, output int tk);
    reqValid <= 1'b1;
    req      <= r;
    do @(posedge sys_clk); while (issueStall_q !== 1'b0);
    tk = edges + 1;
  endtask : issue

  // Released request lines show a changing pattern.
  task automatic idle();
    reqValid <= 1'b0;
    req      <= mdu_pkg::mdu_req_s'(~req);
    @(posedge sys_clk);
  endtask : idle
endmodule : mdu_pipe_model
`default_nettype wire

// File: test/mdu_muldiv_unit_tb.sv
// Self-checking bench of the multiply/divide unit.
`timescale 1ns/1ps
`default_nettype none
module mdu_muldiv_unit_tb;
  typedef struct {int due; bit gpr; logic [31:0] hi; logic [31:0] lo;} mdu_note_s;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              clkEn = 1'b1;
  logic              reqValid;
  logic              issueStall_q;
  logic              gprValid_q;
  mdu_pkg::mdu_req_s req;
  logic [31:0]       resultHigh_q;
  logic [31:0]       resultLow_q;
  logic [31:0]       gprData_q;
  logic [63:0]       pair = '0;
  logic [63:0]       seen = '0;
  mdu_note_s         notes[$];
  int                error_cnt = 0;
  int                compares = 0;
  int                seed = 83734;
  int                cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  mdu_muldiv_unit u_dut (.sys_clk, .rst_n, .clkEn, .reqValid, .req, .issueStall_q,
                         .resultHigh_q, .resultLow_q, .gprValid_q, .gprData_q);
  mdu_pipe_model u_pipe (.sys_clk, .issueStall_q, .reqValid, .req);

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("Counts: compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  // Random operand that fits exactly the given width class.
  function automatic logic [31:0] gen(input int w, input bit s);
    logic [31:0] r;
    r = $random(seed);
    r[w - 1 -: 2] = 2'b10;
    if (s) r = 32'($signed(r << (32 - w)) >>> (32 - w));
    else r = r & 32'((33'h1 << w) - 33'h1);
    return r;
  endfunction : gen

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      error_cnt++;
      finish_test();
    end
  end

  // Takes due notes off the queue and compares them with the outputs.
  always @(negedge sys_clk) begin
    mdu_note_s   keep[$];
    logic        gExp;
    logic [31:0] gData;
    keep.delete();
    gExp  = 1'b0;
    gData = '0;
    foreach (notes[i]) begin
      if (notes[i].due != u_pipe.edges) keep.push_back(notes[i]);
      else if (notes[i].gpr) begin
        gExp  = 1'b1;
        gData = notes[i].lo;
      end
      else seen = {notes[i].hi, notes[i].lo};
    end
    notes = keep;
    check({resultHigh_q, resultLow_q}, seen);
    check({31'h0, gprValid_q, gExp ? gprData_q : 32'h0}, {31'h0, gExp, gData});
  end

  initial begin
    mdu_pkg::mdu_req_s r;
    logic [63:0]       sa;
    logic [63:0]       sb;
    logic [63:0]       p;
    int                k, cls, lat, rep, prevRep, tk, prevTk;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    $display("Test reset done");
    for (int i = 0; i < 80; i++) begin
      k = i % 5;
      cls = (i / 10) % 4;
      r.op = mdu_pkg::mdu_op_e'(k == 3 ? 4 : (k == 4 ? 3 : k));
      r.isSigned = 1'((i / 5) % 2);
      r.firstSrc = gen(r.op == mdu_pkg::MDU_OP_DIV ? 8 * (cls + 1) : 32, r.isSigned);
      r.secondSrc = gen(r.op == mdu_pkg::MDU_OP_DIV ? 16 : 16 * (cls % 2 + 1), r.isSigned);
      if (r.secondSrc == '0) r.secondSrc = 32'h3;
      sa = r.isSigned ? {{32{r.firstSrc[31]}}, r.firstSrc} : {32'h0, r.firstSrc};
      sb = r.isSigned ? {{32{r.secondSrc[31]}}, r.secondSrc} : {32'h0, r.secondSrc};
      p = sa * sb;
      lat = cls % 2 + 1;
      rep = lat;
      case (r.op)
        mdu_pkg::MDU_OP_MULT: pair = p;
        mdu_pkg::MDU_OP_MADD: pair = pair + p;
        mdu_pkg::MDU_OP_MSUB: pair = pair - p;
        mdu_pkg::MDU_OP_MUL3: begin
          lat = lat + 1;
        end
        default: begin
          lat = 12 + 7 * cls;
          rep = lat - 1;
          if (r.isSigned) pair = {32'($signed(r.firstSrc) % $signed(r.secondSrc)),
                                  32'($signed(r.firstSrc) / $signed(r.secondSrc))};
          else pair = {r.firstSrc % r.secondSrc, r.firstSrc / r.secondSrc};
        end
      endcase
      u_pipe.issue(r, tk);
      if (i > 0) check(64'(tk), 64'(prevTk + prevRep));
      if (r.op == mdu_pkg::MDU_OP_MUL3) notes.push_back('{tk + lat - 1, 1'b1, '0, p[31:0]});
      else notes.push_back('{tk + lat - 1, 1'b0, pair[63:32], pair[31:0]});
      prevTk = tk;
      prevRep = rep;
    end
    repeat (40) u_pipe.idle();
    check(64'(notes.size()), 64'h0);
    $display("Test mixed_ops done");
    finish_test();
  end
endmodule : mdu_muldiv_unit_tb
`default_nettype wire
